// file: usu_pkg.sv
package usu_pkg;

  // ***********************************************
  // register map
  // ***********************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_DATA = 8'h08;
  localparam logic [7:0] ADDR_PORT = 8'h0C;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [2:0] PORT_RST = 3'h0;

  // ***********************************************
  // field positions
  // ***********************************************
  localparam int CTRL_START_IE = 7;
  localparam int CTRL_WRAP_IE = 6;
  localparam int CTRL_WM_HI = 5;
  localparam int CTRL_WM_LO = 4;
  localparam int CTRL_CS_HI = 3;
  localparam int CTRL_CS_LO = 2;
  localparam int CTRL_STROBE = 1;
  localparam int CTRL_TOGGLE = 0;
  localparam int STAT_START = 7;
  localparam int STAT_WRAP = 6;
  localparam int PORT_LAT_LSB = 0;
  localparam int PORT_DIR_LSB = 4;
  localparam int PIN_DO = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_SCL = 2;

  typedef enum logic [1:0] {
    WM_OFF = 2'h0,
    WM_THREE = 2'h1,
    WM_TWO = 2'h2,
    WM_TWO_HOLD = 2'h3
  } usu_wire_mode_t;

  typedef enum logic [1:0] {
    CS_SOFT = 2'h0,
    CS_TIMER = 2'h1,
    CS_EXT_POS = 2'h2,
    CS_EXT_NEG = 2'h3
  } usu_clk_src_t;

  // pin drive bundle; oe_n low means driven
  typedef struct packed {
    logic do_o;
    logic do_oe_n;
    logic do_pu_en;
    logic sda_o;
    logic sda_oe_n;
    logic sda_pu_en;
    logic scl_o;
    logic scl_oe_n;
    logic scl_pu_en;
  } usu_pin_out_t;

endpackage : usu_pkg

// file: usu_serial_unit.sv
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
module usu_serial_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_irq_en,
  input wire logic idle_sleep,
  input wire logic timer_match_a,
  input wire logic timer_match,
  input wire logic do_i,
  input wire logic sda_i,
  input wire logic scl_i,
  output usu_pkg::usu_pin_out_t pins,
  output logic start_irq_req,
  output logic wrap_irq_req,
  output logic wake_req
);
  import usu_pkg::*;

  // ***********************************************
  // bus decode
  // ***********************************************
  logic setup;
  logic wr;
  logic hit;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic wr_port;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite;
  assign hit = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT) ||
               (paddr == ADDR_DATA) || (paddr == ADDR_PORT);
  assign wr_ctrl = wr && (paddr == ADDR_CTRL);
  assign wr_stat = wr && (paddr == ADDR_STAT);
  assign wr_data = wr && (paddr == ADDR_DATA);
  assign wr_port = wr && (paddr == ADDR_PORT);
  assign pready = penable;
  assign pslverr = psel && penable && !hit;

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  // lines idle high; a zero reset would fake an edge on release
  localparam logic [2:0] PIN_IDLE = 3'h7;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= PIN_IDLE;
      pin_s2_q <= PIN_IDLE;
      pin_s3_q <= PIN_IDLE;
    end else begin
      pin_s1_q <= {scl_i, sda_i, do_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic sda_fall;

  assign scl_s = pin_s2_q[PIN_SCL];
  assign sda_s = pin_s2_q[PIN_SDA];
  assign scl_rise = scl_s && !pin_s3_q[PIN_SCL];
  assign scl_fall = !scl_s && pin_s3_q[PIN_SCL];
  assign sda_fall = !sda_s && pin_s3_q[PIN_SDA];

  // ***********************************************
  // control register
  // ***********************************************
  logic [7:0] ctrl_q;
  logic cnt_sel_q;
  usu_wire_mode_t wmode;
  usu_clk_src_t csrc;
  logic ext_clk;
  logic two_wire;
  logic strobe_wr;
  logic toggle_wr;
  usu_clk_src_t csrc_eff;
  logic cnt_sel_eff;

  // strobe bits are not stored; the select copy is internal only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= {pwdata[7:2], 2'b00};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_sel_q <= 1'b0;
    end else if (wr_ctrl) begin
      cnt_sel_q <= pwdata[CTRL_STROBE];
    end
  end

  assign wmode = usu_wire_mode_t'(ctrl_q[CTRL_WM_HI:CTRL_WM_LO]);
  assign csrc = usu_clk_src_t'(ctrl_q[CTRL_CS_HI:CTRL_CS_LO]);
  assign ext_clk = ctrl_q[CTRL_CS_HI];
  assign two_wire = (wmode == WM_TWO) || (wmode == WM_TWO_HOLD);
  assign strobe_wr = wr_ctrl && pwdata[CTRL_STROBE];
  assign toggle_wr = wr_ctrl && pwdata[CTRL_TOGGLE];
  // a control write is decoded with the source it writes, so a strobe
  // sent along with a new source follows that source
  assign csrc_eff = wr_ctrl ?
                    usu_clk_src_t'(pwdata[CTRL_CS_HI:CTRL_CS_LO]) : csrc;
  assign cnt_sel_eff = wr_ctrl ? pwdata[CTRL_STROBE] : cnt_sel_q;

  // ***********************************************
  // clock source selection
  // ***********************************************
  logic shift_clk;
  logic cnt_clk;

  always_comb begin
    shift_clk = 1'b0;
    cnt_clk = 1'b0;
    case (csrc_eff)
      CS_SOFT: begin
        shift_clk = strobe_wr;
        cnt_clk = strobe_wr;
      end
      CS_TIMER: begin
        shift_clk = timer_match_a;
        cnt_clk = timer_match;
      end
      CS_EXT_POS: begin
        shift_clk = scl_rise;
        cnt_clk = cnt_sel_eff ? toggle_wr : (scl_rise || scl_fall);
      end
      CS_EXT_NEG: begin
        shift_clk = scl_fall;
        cnt_clk = cnt_sel_eff ? toggle_wr : (scl_rise || scl_fall);
      end
      default: begin
        shift_clk = 1'b0;
        cnt_clk = 1'b0;
      end
    endcase
  end

  // ***********************************************
  // shift register and output latch
  // ***********************************************
  logic [7:0] data_q;
  logic out_lat_q;
  logic din_q;
  logic lat_open;
  logic do_val;

  // input as seen one cycle earlier, so a strobe shifts the old sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_q <= 1'b0;
    end else begin
      din_q <= sda_s;
    end
  end

  // a bus write wins over a shift in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= DATA_RST;
    end else if (wr_data) begin
      data_q <= pwdata[7:0];
    end else if (shift_clk) begin
      data_q <= {data_q[6:0], din_q};
    end
  end

  // latch follows msb on the edge opposite the sampling edge
  assign lat_open = (csrc == CS_EXT_POS) ? scl_fall : scl_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_lat_q <= 1'b0;
    end else if (lat_open) begin
      out_lat_q <= data_q[7];
    end
  end

  // internal sources see the msb directly, no latch delay
  assign do_val = ext_clk ? out_lat_q : data_q[7];

  // ***********************************************
  // counter
  // ***********************************************
  logic [3:0] cnt_q;
  logic cnt_wrap;

  assign cnt_wrap = cnt_clk && (cnt_q == CNT_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= CNT_RST;
    end else if (wr_stat) begin
      cnt_q <= pwdata[3:0];
    end else if (cnt_clk) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // ***********************************************
  // flags
  // ***********************************************
  logic start_q;
  logic wrap_q;
  logic start_ev;

  // start event: in two-wire modes sda falls while scl stays high, in other modes any scl edge
  assign start_ev = two_wire ? (sda_fall && scl_s)
                             : (scl_rise || scl_fall);

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
    end else if (start_ev) begin
      start_q <= 1'b1;
    end else if (wr_stat && pwdata[STAT_START]) begin
      start_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_q <= 1'b0;
    end else if (cnt_wrap) begin
      wrap_q <= 1'b1;
    end else if (wr_stat && pwdata[STAT_WRAP]) begin
      wrap_q <= 1'b0;
    end
  end

  // levels held for as long as the flag stands
  assign start_irq_req = start_q && ctrl_q[CTRL_START_IE] &&
                         global_irq_en;
  assign wrap_irq_req = wrap_q && ctrl_q[CTRL_WRAP_IE] &&
                        global_irq_en;
  // limitation: detection is sampled, so this clock must keep running
  assign wake_req = start_irq_req ||
                    (wrap_irq_req && idle_sleep);

  // ***********************************************
  // port latch and direction
  // ***********************************************
  logic [2:0] lat_q;
  logic [2:0] dir_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_q <= PORT_RST;
    end else if (wr_port) begin
      lat_q <= pwdata[PORT_LAT_LSB +: 3];
    end else if (toggle_wr) begin
      lat_q[PIN_SCL] <= !lat_q[PIN_SCL];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= PORT_RST;
    end else if (wr_port) begin
      dir_q <= pwdata[PORT_DIR_LSB +: 3];
    end
  end

  // ***********************************************
  // pin drive
  // ***********************************************
  logic scl_hold;

  assign scl_hold = two_wire && (start_q ||
                    ((wmode == WM_TWO_HOLD) && wrap_q));

  always_comb begin
    pins.do_o = lat_q[PIN_DO];
    pins.do_oe_n = !dir_q[PIN_DO];
    pins.do_pu_en = lat_q[PIN_DO] && !dir_q[PIN_DO];
    pins.sda_o = lat_q[PIN_SDA];
    pins.sda_oe_n = !dir_q[PIN_SDA];
    pins.sda_pu_en = lat_q[PIN_SDA] && !dir_q[PIN_SDA];
    pins.scl_o = lat_q[PIN_SCL];
    pins.scl_oe_n = !dir_q[PIN_SCL];
    pins.scl_pu_en = lat_q[PIN_SCL] && !dir_q[PIN_SCL];
    case (wmode)
      WM_THREE: begin
        pins.do_o = do_val;
      end
      WM_TWO, WM_TWO_HOLD: begin
        // open drain: only ever pulls low
        pins.sda_o = 1'b0;
        pins.sda_oe_n = !(dir_q[PIN_SDA] &&
                          (!do_val || !lat_q[PIN_SDA]));
        pins.sda_pu_en = 1'b0;
        pins.scl_o = 1'b0;
        pins.scl_oe_n = !(dir_q[PIN_SCL] &&
                          (!lat_q[PIN_SCL] || scl_hold));
        pins.scl_pu_en = 1'b0;
      end
      default: begin
        pins.do_o = lat_q[PIN_DO];
      end
    endcase
  end

  // ***********************************************
  // read data
  // ***********************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    case (paddr)
      ADDR_CTRL: rd_mux[7:0] = ctrl_q;
      ADDR_STAT: begin
        rd_mux[STAT_START] = start_q;
        rd_mux[STAT_WRAP] = wrap_q;
        rd_mux[3:0] = cnt_q;
      end
      ADDR_DATA: rd_mux[7:0] = data_q;
      ADDR_PORT: begin
        rd_mux[PORT_LAT_LSB +: 3] = lat_q;
        rd_mux[PORT_DIR_LSB +: 3] = dir_q;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

endmodule : usu_serial_unit

// file: usu_props.sv
`timescale 1ns/100ps
module usu_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic global_irq_en,
  input wire logic idle_sleep,
  input wire usu_pkg::usu_pin_out_t pins,
  input wire logic start_irq_req,
  input wire logic wrap_irq_req,
  input wire logic wake_req
);
  import usu_pkg::*;
  logic wr;
  logic clr;
  logic [1:0] mode_q;
  logic [2:0] lat_q;
  logic [2:0] dir_q;
  assign wr = psel && penable && pwrite;
  assign clr = wr && (paddr == ADDR_CTRL || (paddr == ADDR_STAT &&
    pwdata[STAT_WRAP]));
  // ****************
  // shadow state
  // ****************
  // shadowed from bus writes, so it moves on the same edge as the design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 2'h0;
    end else if (wr && paddr == ADDR_CTRL) begin
      mode_q <= pwdata[5:4];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_q <= PORT_RST;
      dir_q <= PORT_RST;
    end else if (wr && paddr == ADDR_PORT) begin
      lat_q <= pwdata[2:0];
      dir_q <= pwdata[6:4];
    end else if (wr && paddr == ADDR_CTRL && pwdata[CTRL_TOGGLE]) begin
      lat_q[PIN_SCL] <= ~lat_q[PIN_SCL];
    end
  end
  // ****************
  // properties
  // ****************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a drop with the enable steady must come from a software write
  sequence wrap_drop_s;
    $fell(wrap_irq_req) && global_irq_en && $past(global_irq_en);
  endsequence
  wake_mix_a: assert property (
    wake_req == (start_irq_req || (wrap_irq_req && idle_sleep)))
    else $error("wake request mismatch");
  irq_gate_a: assert property (
    start_irq_req || wrap_irq_req |-> global_irq_en)
    else $error("request without global enable");
  wrap_keep_a: assert property (
    wrap_drop_s |-> $past(clr))
    else $error("wrap request dropped by itself");
  pullup_off_a: assert property (
    mode_q[1] |-> !pins.sda_pu_en && !pins.scl_pu_en)
    else $error("pull-up left on in two-wire mode");
  do_dir_a: assert property (
    !mode_q[1] |-> pins.do_oe_n == !dir_q[PIN_DO])
    else $error("data pin drive ignores direction");
  do_port_a: assert property (
    mode_q == WM_OFF && !pins.do_oe_n |-> pins.do_o == lat_q[PIN_DO])
    else $error("data pin not plain port when off");
  three_scl_a: assert property (
    mode_q == WM_THREE && dir_q[PIN_SCL] |->
    !pins.scl_oe_n && pins.scl_o == lat_q[PIN_SCL])
    else $error("clock pin not following latch");
  sda_low_a: assert property (
    mode_q[1] && dir_q[PIN_SDA] && !lat_q[PIN_SDA] |->
    !pins.sda_oe_n && !pins.sda_o)
    else $error("data line not pulled low");
  scl_low_a: assert property (
    mode_q[1] && dir_q[PIN_SCL] && !lat_q[PIN_SCL] |->
    !pins.scl_oe_n && !pins.scl_o)
    else $error("clock line not pulled low");
  scl_hold_a: assert property (
    mode_q[1] && dir_q[PIN_SCL] && (start_irq_req ||
    (mode_q == WM_TWO_HOLD && wrap_irq_req)) |-> !pins.scl_oe_n)
    else $error("clock line not held");
endmodule : usu_props

// file: usu_peer.sv
`timescale 1ns/100ps
module usu_peer (
  output logic scl,
  output logic sda
);
  // bus pulled high; the clock stands still between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // msb first, data moves while clock low; hp is half the clock period
  task automatic frame(input logic [7:0] b, input int n, input int hp);
    #7;
    for (int i = 0; i < n; i++) begin
      scl = 1'b0;
      sda = b[7 - i];
      #hp;
      scl = 1'b1;
      #hp;
    end
    sda = 1'b1;
  endtask : frame
  task automatic start_cond();
    #7;
    sda = 1'b0;
    #100;
    sda = 1'b1;
  endtask : start_cond
endmodule : usu_peer

// file: testbench.sv
`timescale 1ns/100ps
module testbench;
  import usu_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic gie, idle, tma, tm, do_i, sda_i, scl_i, p_scl, p_sda;
  logic start_irq_req, wrap_irq_req, wake_req;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  usu_pin_out_t pins;
  int fails, samples_checked;
  usu_serial_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_en(gie), .idle_sleep(idle), .timer_match_a(tma),
    .timer_match(tm), .do_i(do_i), .sda_i(sda_i), .scl_i(scl_i),
    .pins(pins), .start_irq_req(start_irq_req),
    .wrap_irq_req(wrap_irq_req), .wake_req(wake_req));
  usu_peer peer_u (.scl(p_scl), .sda(p_sda));
  // wired lines: a driver only wins where it pulls low
  assign scl_i = p_scl & (pins.scl_oe_n | pins.scl_o);
  assign sda_i = p_sda & (pins.sda_oe_n | pins.sda_o);
  assign do_i = pins.do_oe_n ? 1'b1 : pins.do_o;
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : put
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc
  task automatic conclude();
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  initial begin
    #20us;
    fails++;
    conclude();
  end
  initial begin
    {fails, samples_checked} = 0;
    {presetn, psel, penable, pwrite, gie, idle, tma, tm} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(ADDR_CTRL, {24'h0, CTRL_RST});
    put(ADDR_CTRL, 32'h13);
    rdc(ADDR_CTRL, 32'h10);
    rdc(ADDR_STAT, 32'h01);
    rdc(ADDR_PORT, 32'h04);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    put(ADDR_PORT, 32'h54);
    put(ADDR_DATA, 32'hA5);
    chk(32'(pins.do_o), 32'h1);
    put(ADDR_CTRL, 32'h12);
    chk(32'(pins.do_o), 32'h0);
    rdc(ADDR_DATA, 32'h4B);
    gie <= 1'b1;
    idle <= 1'b1;
    put(ADDR_CTRL, 32'h40);
    put(ADDR_STAT, 32'h0F);
    put(ADDR_CTRL, 32'h42);
    rdc(ADDR_STAT, 32'h40);
    chk(32'(wrap_irq_req), 32'h1);
    chk(32'(wake_req), 32'h1);
    put(ADDR_STAT, 32'h00);
    rdc(ADDR_STAT, 32'h40);
    put(ADDR_STAT, 32'h40);
    chk(32'(wrap_irq_req), 32'h0);
    put(ADDR_DATA, 32'h01);
    put(ADDR_CTRL, 32'h06);
    {tma, tm} <= 2'h3;
    @(posedge pclk);
    {tma, tm} <= 2'h0;
    @(posedge pclk);
    rdc(ADDR_STAT, 32'h01);
    rdc(ADDR_DATA, 32'h03);
    put(ADDR_PORT, 32'h14);
    put(ADDR_DATA, 32'h00);
    put(ADDR_STAT, 32'h00);
    put(ADDR_CTRL, 32'h18);
    peer_u.frame(8'hC3, 4, 100);
    @(posedge pclk);
    rdc(ADDR_STAT, 32'h88);
    rdc(ADDR_DATA, 32'h0C);
    put(ADDR_STAT, 32'h80);
    put(ADDR_PORT, 32'h46);
    put(ADDR_CTRL, 32'hB8);
    peer_u.start_cond();
    @(posedge pclk);
    chk(32'(start_irq_req), 32'h1);
    chk(32'(wake_req), 32'h1);
    chk(32'(pins.scl_oe_n), 32'h0);
    put(ADDR_STAT, 32'h80);
    chk(32'(pins.scl_oe_n), 32'h1);
    put(ADDR_STAT, 32'h0F);
    put(ADDR_CTRL, 32'hFB);
    rdc(ADDR_STAT, 32'h40);
    put(ADDR_CTRL, 32'hFB);
    chk(32'(pins.scl_oe_n), 32'h0);
    put(ADDR_STAT, 32'h40);
    chk(32'(pins.scl_oe_n), 32'h1);
    put(ADDR_PORT, 32'h64);
    chk(32'(pins.sda_oe_n), 32'h0);
    chk(32'(pins.sda_pu_en), 32'h0);
    conclude();
  end
endmodule : testbench
bind usu_serial_unit usu_props props_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .global_irq_en(global_irq_en),
  .idle_sleep(idle_sleep), .pins(pins), .start_irq_req(start_irq_req),
  .wrap_irq_req(wrap_irq_req), .wake_req(wake_req));
